// [tv_pwm_defs.vh]
// register map, field layout and timing constants of the pwm outputs
`ifndef TV_PWM_DEFS_VH
`define TV_PWM_DEFS_VH

// register indices as printed; byte address is four times the index
`define IDX_DAC_CH0 8'hE0
`define IDX_DAC_CH1 8'hE1
`define IDX_DAC_CH2 8'hE2
`define IDX_DAC_CH3 8'hE3
`define IDX_TUNE_LOW 8'hED
`define IDX_TUNE_HIGH 8'hEE

// word index taken from haddr
`define ADDR_IDX_MSB 9
`define ADDR_IDX_LSB 2
`define ADDR_IDX_W 8

// dac control fields
`define DAC_DUTY_MSB 5
`define DAC_DUTY_LSB 0
`define DAC_ENABLE_BIT 6
`define DAC_EXTRA_BIT 7

// tuning word fields
`define TUNE_W 14
`define TUNE_HIGH_W 6
`define TUNE_COARSE_MSB 13
`define TUNE_COARSE_LSB 7
`define TUNE_FINE_MSB 6
`define TUNE_FINE_LSB 0

// reset values; content is undefined, zero is used
`define RST_DAC_CTRL 8'h00
`define RST_TUNE_LOW 8'h00
`define RST_TUNE_HIGH 6'h00

// clock and output rates in hertz
`define SYS_CLK_HZ 10000000
`define TUNE_CLK_HZ 2000000
`define DAC_REP_HZ 31250
`define DAC_STEPS 64
`define SQUARE_HZ 62500

// derived cycle counts
`define TUNE_DIV_CYC (`SYS_CLK_HZ / `TUNE_CLK_HZ)
`define DAC_DIV_CYC (`SYS_CLK_HZ / (`DAC_REP_HZ * `DAC_STEPS))
`define SQUARE_HALF_CYC (`SYS_CLK_HZ / (2 * `SQUARE_HZ))

`endif

// [tuning_and_dac_pwm_outputs.v]
// tuning pwm/brm generator, four pwm dacs and square-wave pin
//
// Function
// [R01] tuning output built from 14-bit reference counter
// [R02] tuning word split over two registers
// [R03] upper seven coarse width, lower seven fine
// [R04] zero stays low, pulses grow to 128
// [R05] above 128, pulses widen by coarse bits
// [R06] all ones leaves single one-count low pulse
// [R07] reference counter advances at 2 MHz rate
// [R08] fine bits insert pulses by halving cycle pattern
// [R09] low register holds eight least significant bits
// [R10] high register holds six msbs, rest unused
// [R11] per-channel prescaler clocks free 6-bit compare counter
// [R12] four dac registers drive four channels in order
// [R13] zero gives high, all ones 1/64 duty
// [R14] enable bit clear forces channel low
// [R15] zero duty lets output follow enable only
// [R16] dac pattern repeats at 31.25 kHz
// [R17] select bit gives 62.5 kHz square, 50% duty
// [R18] otherwise pin drives software bit, open drain
// [R19] first dac register fields undefined after reset
// [R20] software bit shown only while select is clear
// [R21] high below coarse, plus one selected count
`timescale 1ns/1ps
`include "tv_pwm_defs.vh"

module tuning_and_dac_pwm_outputs
(
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // tuning output, push-pull
  output reg tuning_voltage_pin,
  // dac pins, open drain: output value and enable
  output reg [3:0] dac_output_pins_o,
  output reg [3:0] dac_output_pins_oe,
  // square wave or general purpose pin, open drain
  output reg square_wave_or_gp_pin_o,
  output reg square_wave_or_gp_pin_oe
);

  localparam integer TUNE_DIV_N = `TUNE_DIV_CYC;
  localparam integer DAC_DIV_N = `DAC_DIV_CYC;
  localparam integer SQUARE_HALF_N = `SQUARE_HALF_CYC;
  // dividers are eight bits; every count at this clock stays below 256
  localparam [7:0] TUNE_DIV = TUNE_DIV_N[7:0];
  localparam [7:0] DAC_DIV = DAC_DIV_N[7:0];
  localparam [7:0] SQUARE_HALF = SQUARE_HALF_N[7:0];
  localparam [7:0] IDX_CH0 = `IDX_DAC_CH0;
  localparam [7:0] IDX_CH1 = `IDX_DAC_CH1;
  localparam [7:0] IDX_CH2 = `IDX_DAC_CH2;
  localparam [7:0] IDX_CH3 = `IDX_DAC_CH3;
  localparam [7:0] IDX_LOW = `IDX_TUNE_LOW;
  localparam [7:0] IDX_HIGH = `IDX_TUNE_HIGH;

  // register file
  reg [7:0] dac_channel0_ctrl;
  reg [7:0] dac_channel1_ctrl;
  reg [7:0] dac_channel2_ctrl;
  reg [7:0] dac_channel3_ctrl;
  reg [7:0] tuning_word_low;
  reg [`TUNE_HIGH_W-1:0] tuning_word_high;

  // ahb data-phase state
  reg wr_pending;
  reg [7:0] wr_idx;
  wire [7:0] addr_idx;
  wire xfer_ok;
  reg [31:0] next_hrdata;

  assign addr_idx = haddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
  // every nonseq or seq transfer that selects this slave is acted on; hsize and the low address bits are not checked
  assign xfer_ok = hsel & htrans[1] & hready;

  // address phase: capture writes, prepare read data
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pending <= 1'b0;
      wr_idx <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready)
      begin
        wr_pending <= xfer_ok & hwrite;
        wr_idx <= addr_idx;
        if (xfer_ok & ~hwrite)
        begin
          hrdata <= next_hrdata;
        end
        else
        begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  // read mux; unmapped words read as zero
  always @*
  begin
    next_hrdata = 32'h0000_0000;
    case (addr_idx)
      IDX_CH0: next_hrdata = {24'h00_0000, dac_channel0_ctrl};
      IDX_CH1: next_hrdata = {24'h00_0000, dac_channel1_ctrl};
      IDX_CH2: next_hrdata = {24'h00_0000, dac_channel2_ctrl};
      IDX_CH3: next_hrdata = {24'h00_0000, dac_channel3_ctrl};
      IDX_LOW: next_hrdata = {24'h00_0000, tuning_word_low}; // [R09]
      IDX_HIGH: next_hrdata = {26'h000_0000, tuning_word_high}; // [R10]
      default: next_hrdata = 32'h0000_0000;
    endcase
    // a write still in its data phase lands only at this edge, so a
    // pipelined read of the same word must see the incoming value
    if (wr_pending && (wr_idx == addr_idx))
    begin
      case (wr_idx)
        IDX_CH0, IDX_CH1, IDX_CH2, IDX_CH3, IDX_LOW:
          next_hrdata = {24'h00_0000, hwdata[7:0]};
        IDX_HIGH:
          next_hrdata = {26'h000_0000, hwdata[5:0]};
        default:
          next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // data phase: write the addressed register
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dac_channel0_ctrl <= `RST_DAC_CTRL; // [R19]
      dac_channel1_ctrl <= `RST_DAC_CTRL;
      dac_channel2_ctrl <= `RST_DAC_CTRL;
      dac_channel3_ctrl <= `RST_DAC_CTRL;
      tuning_word_low <= `RST_TUNE_LOW;
      tuning_word_high <= `RST_TUNE_HIGH;
    end
    else if (wr_pending)
    begin
      case (wr_idx)
        IDX_CH0: dac_channel0_ctrl <= hwdata[7:0]; // [R12]
        IDX_CH1: dac_channel1_ctrl <= hwdata[7:0]; // [R12]
        IDX_CH2: dac_channel2_ctrl <= hwdata[7:0]; // [R12]
        IDX_CH3: dac_channel3_ctrl <= hwdata[7:0]; // [R12]
        IDX_LOW: tuning_word_low <= hwdata[7:0]; // [R02]
        IDX_HIGH: tuning_word_high <= hwdata[5:0]; // [R02]
        default:
        begin
        end
      endcase
    end
  end

  // tuning generator
  wire [`TUNE_W-1:0] tune_word;
  reg [`TUNE_W-1:0] tune_shadow;
  reg [7:0] tune_div_cnt;
  reg tune_tick;
  reg [`TUNE_W-1:0] tune_cnt;
  wire [6:0] coarse;
  wire [6:0] fine;
  wire [6:0] pos;
  wire [6:0] cycle;
  wire [6:0] fine_hit;
  reg next_tune_level;

  assign tune_word = {tuning_word_high, tuning_word_low}; // [R02]

  // 2 mhz enable from the system clock
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tune_div_cnt <= 8'h00;
      tune_tick <= 1'b0;
    end
    else if (tune_div_cnt == TUNE_DIV - 8'h01)
    begin
      tune_div_cnt <= 8'h00;
      tune_tick <= 1'b1; // [R07]
    end
    else
    begin
      tune_div_cnt <= tune_div_cnt + 8'h01;
      tune_tick <= 1'b0;
    end
  end

  // word is reloaded only at period start so a split write of the
  // two halves cannot produce one odd period mid-way
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tune_cnt <= 14'h0000;
      tune_shadow <= 14'h0000;
    end
    else if (tune_tick)
    begin
      tune_cnt <= tune_cnt + 14'h0001; // [R01]
      if (tune_cnt == 14'h3FFF)
      begin
        tune_shadow <= tune_word;
      end
    end
  end

  assign coarse = tune_shadow[`TUNE_COARSE_MSB:`TUNE_COARSE_LSB]; // [R03]
  assign fine = tune_shadow[`TUNE_FINE_MSB:`TUNE_FINE_LSB]; // [R03]
  assign pos = tune_cnt[6:0];
  assign cycle = tune_cnt[13:7];

  // fine bit k selects cycles whose lowest set bit is 6-k
  genvar k;
  generate
    for (k = 0; k < 7; k = k + 1)
    begin : g_brm
      localparam [6:0] LOW_MASK = (7'h01 << (6 - k)) - 7'h01;
      assign fine_hit[k] = fine[k] & cycle[6-k] &
                           ((cycle & LOW_MASK) == 7'h00); // [R08]
    end
  endgenerate

  // high below coarse; one extra count when the fine table picks it
  always @*
  begin
    next_tune_level = 1'b0;
    if (pos < coarse)
    begin
      next_tune_level = 1'b1; // [R21] [R05]
    end
    else if ((pos == coarse) && (fine_hit != 7'h00))
    begin
      next_tune_level = 1'b1; // [R21] [R04] [R06]
    end
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tuning_voltage_pin <= 1'b0;
    end
    else
    begin
      tuning_voltage_pin <= next_tune_level;
    end
  end

  // dac channels
  wire [31:0] dac_ctrl_flat;
  wire [3:0] next_dac_level;

  assign dac_ctrl_flat = {dac_channel3_ctrl, dac_channel2_ctrl,
                          dac_channel1_ctrl, dac_channel0_ctrl};

  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1)
    begin : g_dac
      reg [7:0] pre_cnt;
      reg [5:0] step_cnt;
      wire [7:0] ctrl;
      wire [5:0] duty;
      wire dac_channel_enable;
      assign ctrl = dac_ctrl_flat[8*c+7:8*c];
      assign duty = ctrl[`DAC_DUTY_MSB:`DAC_DUTY_LSB];
      assign dac_channel_enable = ctrl[`DAC_ENABLE_BIT];
      // each channel keeps its own prescaler, as on the real cell
      always @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pre_cnt <= 8'h00;
          step_cnt <= 6'h00;
        end
        else if (pre_cnt == DAC_DIV - 8'h01)
        begin
          pre_cnt <= 8'h00;
          step_cnt <= step_cnt + 6'h01; // [R11] [R16]
        end
        else
        begin
          pre_cnt <= pre_cnt + 8'h01;
        end
      end
      // high while step at or above duty: zero gives steady high
      assign next_dac_level[c] = dac_channel_enable &
                                 (step_cnt >= duty); // [R13] [R14] [R15]
    end
  endgenerate

  // open drain: enable pulls the pin low
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dac_output_pins_o <= 4'h0;
      dac_output_pins_oe <= 4'hF;
    end
    else
    begin
      dac_output_pins_o <= 4'h0;
      dac_output_pins_oe <= ~next_dac_level; // [R14]
    end
  end

  // square wave
  reg [7:0] sq_cnt;
  reg sq_level;
  wire square_wave_select;
  wire gp_data;
  wire next_sq_pin;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sq_cnt <= 8'h00;
      sq_level <= 1'b0;
    end
    else if (sq_cnt == SQUARE_HALF - 8'h01)
    begin
      sq_cnt <= 8'h00;
      sq_level <= ~sq_level; // [R17]
    end
    else
    begin
      sq_cnt <= sq_cnt + 8'h01;
    end
  end

  assign square_wave_select = dac_channel0_ctrl[`DAC_EXTRA_BIT];
  assign gp_data = dac_channel1_ctrl[`DAC_EXTRA_BIT];
  // select wins; the software bit is ignored while the square runs
  assign next_sq_pin = square_wave_select ? sq_level :
                       gp_data; // [R17] [R18] [R20]

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      square_wave_or_gp_pin_o <= 1'b0;
      square_wave_or_gp_pin_oe <= 1'b1;
    end
    else
    begin
      square_wave_or_gp_pin_o <= 1'b0;
      square_wave_or_gp_pin_oe <= ~next_sq_pin; // [R18]
    end
  end

endmodule // tuning_and_dac_pwm_outputs

// [pwm_outputs_asserts.sv]
// assertions on the pwm output block ports
`timescale 1ns/1ps
`include "tv_pwm_defs.vh"
module pwm_outputs_asserts
(
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  // pins
  input wire tuning_voltage_pin,
  input wire [3:0] dac_output_pins_o,
  input wire [3:0] dac_output_pins_oe,
  input wire square_wave_or_gp_pin_o,
  input wire square_wave_or_gp_pin_oe
);
  reg pend;
  reg [7:0] idx;
  reg [7:0] ch0;
  reg [7:0] ch1;
  reg [7:0] quiet;
  reg [7:0] run;
  reg prev;
  wire tv = tuning_voltage_pin;
  wire [3:0] oe = dac_output_pins_oe;
  wire sq = square_wave_or_gp_pin_oe;
  wire hit = pend && hready;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // quiet masks the four edges after a write to dac channel 0 or 1; a pin lags its register by one edge
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {pend, idx, ch0, ch1, quiet, run, prev} <= 42'h0;
    end
    else
    begin
      if (hready)
      begin
        pend <= hsel && htrans[1] && hwrite;
        idx <= haddr[9:2];
      end
      if (hit && idx == `IDX_DAC_CH0)
        ch0 <= hwdata[7:0];
      if (hit && idx == `IDX_DAC_CH1)
        ch1 <= hwdata[7:0];
      if (hit && idx[7:1] == 7'h70)
        quiet <= 8'h00;
      else if (quiet != 8'hFF)
        quiet <= quiet + 8'h01;
      prev <= sq;
      run <= (prev != sq) ? 8'h01 : run + 8'h01;
    end
  end
  chk_open_drain: assert property (
    dac_output_pins_o == 4'h0 && !square_wave_or_gp_pin_o)
    else $error("open-drain data not low");
  chk_tune_high: assert property (
    $rose(tv) |-> tv[*5])
    else $error("tuning high shorter than a step");
  chk_tune_low: assert property (
    $fell(tv) |-> !tv[*5])
    else $error("tuning low shorter than a step");
  chk_dac_step: assert property (
    quiet > 8'h08 && $rose(oe[0]) |-> (oe[0] || quiet < 8'h04)[*5])
    else $error("dac low shorter than a step");
  chk_dac_off: assert property (
    quiet > 8'h03 && !ch0[6] |-> oe[0])
    else $error("disabled dac not low");
  chk_dac_zero: assert property (
    quiet > 8'h03 && ch1[6] && ch1[5:0] == 6'h00 |-> !oe[1])
    else $error("zero duty dac not high");
  chk_gp_pin: assert property (
    quiet > 8'h03 && !ch0[7] |-> sq == !ch1[7])
    else $error("gp pin not following its bit");
  chk_sq_half: assert property (
    quiet > 8'hC8 && ch0[7] && $changed(sq) |-> run == 8'h50)
    else $error("square half period wrong");
endmodule // pwm_outputs_asserts

bind tuning_and_dac_pwm_outputs pwm_outputs_asserts u_chk
(
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .tuning_voltage_pin(tuning_voltage_pin),
  .dac_output_pins_o(dac_output_pins_o),
  .dac_output_pins_oe(dac_output_pins_oe),
  .square_wave_or_gp_pin_o(square_wave_or_gp_pin_o),
  .square_wave_or_gp_pin_oe(square_wave_or_gp_pin_oe)
);

// [pwm_pin_loads.sv]
// far-side load: pull-ups on open-drain pins, high-time counters
`timescale 1ns/1ps
module pwm_pin_loads
(
  // clock and window restart
  input wire clk_sys,
  input wire clr,
  // pins
  input wire tv,
  input wire [3:0] dac_o,
  input wire [3:0] dac_oe,
  input wire sq_o,
  input wire sq_oe,
  // high cycles in the window
  output int hi_tv,
  output int hi_dac [4],
  output int hi_sq
);
  // a released pin floats to the pull-up
  wire [3:0] lvl = ~dac_oe | dac_o;
  wire sq_lvl = ~sq_oe | sq_o;
  always @(posedge clk_sys)
  begin
    hi_tv <= (clr ? 0 : hi_tv) + tv;
    hi_sq <= (clr ? 0 : hi_sq) + sq_lvl;
    for (int c = 0; c < 4; c++)
      hi_dac[c] <= (clr ? 0 : hi_dac[c]) + lvl[c];
  end
endmodule // pwm_pin_loads

// [tuning_and_dac_pwm_outputs_tb.sv]
// self-checking bench for the tuning and dac pwm outputs
`timescale 1ns/1ps
`include "tv_pwm_defs.vh"
module tuning_and_dac_pwm_outputs_tb;
  reg clk_sys;
  reg rst_n;
  reg hsel;
  reg [31:0] haddr;
  reg [1:0] htrans;
  reg hwrite;
  reg [31:0] hwdata;
  reg clr;
  wire rdy;
  wire hresp;
  wire [31:0] hrdata;
  wire tv;
  wire [3:0] dac_o;
  wire [3:0] dac_oe;
  wire sq_o;
  wire sq_oe;
  logic [31:0] q;
  int hi_tv;
  int hi_dac [4];
  int hi_sq;
  int mismatches;
  int tests_run;
  int cycles;
  // register walk: index, value written, value read back
  logic [7:0] idx_t [7] = '{`IDX_DAC_CH0, `IDX_DAC_CH1, `IDX_DAC_CH2,
    `IDX_DAC_CH3, `IDX_TUNE_LOW, `IDX_TUNE_HIGH, 8'hE5};
  logic [7:0] wr_t [7] = '{8'h80, 8'hC0, 8'h7F, 8'h60, 8'hFF, 8'hFF, 8'hAA};
  logic [7:0] rd_t [7] = '{8'h80, 8'hC0, 8'h7F, 8'h60, 8'hFF, 8'h3F, 8'h00};

  tuning_and_dac_pwm_outputs dut
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(rdy), .hreadyout(rdy), .hresp(hresp), .hrdata(hrdata),
    .tuning_voltage_pin(tv), .dac_output_pins_o(dac_o),
    .dac_output_pins_oe(dac_oe), .square_wave_or_gp_pin_o(sq_o),
    .square_wave_or_gp_pin_oe(sq_oe)
  );
  pwm_pin_loads load
  (
    .clk_sys(clk_sys), .clr(clr), .tv(tv), .dac_o(dac_o), .dac_oe(dac_oe),
    .sq_o(sq_o), .sq_oe(sq_oe), .hi_tv(hi_tv), .hi_dac(hi_dac),
    .hi_sq(hi_sq)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task end_sim;
  begin
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 100000)
    begin
      mismatches++;
      end_sim;
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
  begin
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %0d, want %0d", $time, got, exp);
    end
  end
  endtask

  task automatic bus(input [7:0] idx, input wr, input [7:0] d);
  begin
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'b00};
    @(posedge clk_sys);
    while (rdy !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    @(posedge clk_sys);
    while (rdy !== 1'b1) @(posedge clk_sys);
    q = hrdata;
  end
  endtask

  // counts cover n edges, starting with the one that restarts the window
  task automatic meas(input int n);
  begin
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (n) @(posedge clk_sys);
  end
  endtask

  // 640 cycles is two dac periods, so window phase does not matter
  task automatic phase(input [7:0] idx, input [7:0] d,
    input int e0, input int e1, input int e2, input int e3, input int es);
  begin
    bus(idx, 1'b1, d);
    repeat (4) @(posedge clk_sys);
    meas(640);
    cmp(hi_dac[0], e0);
    cmp(hi_dac[1], e1);
    cmp(hi_dac[2], e2);
    cmp(hi_dac[3], e3);
    cmp(hi_sq, es);
    cmp(hi_tv, 0);
  end
  endtask

  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    clr = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 7; i++)
      bus(idx_t[i], 1'b1, wr_t[i]);
    for (int i = 0; i < 7; i++)
    begin
      bus(idx_t[i], 1'b0, 8'h00);
      cmp(q, {24'h0, rd_t[i]});
      cmp({31'h0, hresp}, 32'h0000_0000);
    end
    phase(`IDX_DAC_CH2, 8'h7F, 0, 640, 10, 320, 320);
    phase(`IDX_DAC_CH0, 8'h45, 590, 640, 10, 320, 640);
    phase(`IDX_DAC_CH1, 8'h40, 590, 640, 10, 320, 0);
    // all-ones word takes effect at the first period wrap
    @(posedge clk_sys);
    while (tv !== 1'b1) @(posedge clk_sys);
    meas(1280);
    cmp(hi_tv, 1275);
    end_sim;
  end
endmodule // tuning_and_dac_pwm_outputs_tb
